// ### include/seepc_pkg.sv
/*
  shared constants and types for the serial eeprom program/erase control:
  instruction codes, field widths, delivery value, timing counts, state enums.
  assumes a single 20 MHz system clock on both ends.
*/
package seepc_pkg;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam logic START_BIT = 1'b1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam int OPCODE_W = 2;
  localparam int BYTE_DATA_W = 8;
  localparam int WORD_DATA_W = 16;
  localparam int ADDR_W_DEF = 9;
  localparam int FRAME_W = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int PROG_TIME_US = 100;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SELECT_LOW_TO_HIGH_DELAY_NS = 250;
  localparam int SLSH_CYCLES =
    (SELECT_LOW_TO_HIGH_DELAY_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int SCLK_HALF_CYCLES_DEF = 5;
  // must cover the device's select sync and status register plus our own
  // two-flop sync, or the released (pulled-high) line reads as ready
  localparam int POLL_SETTLE_CYCLES = 6;

  // ----------------------------------------------------------------
  // states and commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h1,
    DEV_TIMED = 3'h2,
    DEV_APPLY = 3'h4
  } seepc_dev_st_type;

  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_SHIFT = 4'h2,
    HST_GAP = 4'h4,
    HST_POLL = 4'h8
  } seepc_hst_st_type;

  typedef enum logic [2:0] {
    CMD_WRITE = 3'h0,
    CMD_ERASE = 3'h1,
    CMD_ERASE_ALL = 3'h2,
    CMD_FILL = 3'h3,
    CMD_UNLOCK = 3'h4,
    CMD_LOCK = 3'h5
  } seepc_cmd_type;

endpackage

// ### include/seepc_link_if.sv
/*
  serial link between the bus master and the eeprom device end.
  assumes the testbench joins both ends; an undriven data output reads high.
*/
`timescale 1ns/1ps
interface seepc_link_if;
  logic cs;
  logic sclk;
  logic sdi;
  logic sdo_out;
  logic sdo_oe_n;
  logic sdo_line;

  // ----------------------------------------------------------------
  // wire resolution: pulled high while released
  // ----------------------------------------------------------------
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;

  modport dev (
    input cs,
    input sclk,
    input sdi,
    output sdo_out,
    output sdo_oe_n
  );

  modport host (
    output cs,
    output sclk,
    output sdi,
    input sdo_line
  );
endinterface

// ### rtl/seepc_device.sv
/*
  eeprom device end: instruction capture, clock pulse counting, self-timed
  erase/program cycle, ready/busy on the serial output, and the byte array.
  assumes link pins are asynchronous to clk and the sclk is far below clk/4.
*/
`timescale 1ns/1ps
module seepc_device
  import seepc_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  seepc_link_if.dev link,
  input wire logic word_width_select,
  input wire logic [ADDR_W-1:0] peek_addr,
  output logic [7:0] peek_data,
  output logic busy
);

  localparam int NBYTES = 2 ** ADDR_W;
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic sck_m;
    logic sck_s;
    logic sck_p;
    logic sdi_m;
    logic sdi_s;
    logic in_frame;
    logic [5:0] cnt;
    logic [FRAME_W-1:0] sr;
    seepc_dev_st_type st;
    logic prog;
    logic pass;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
    logic [ADDR_W-1:0] idx;
    logic [15:0] data;
    logic [TW-1:0] timer;
    logic locked;
    logic stat_en;
    logic sdo_out;
    logic sdo_oe_n;
    logic busy;
    logic [7:0] peek;
  } seepc_dev_reg_type;

  seepc_dev_reg_type r;
  seepc_dev_reg_type n;

  logic [7:0] mem [NBYTES];
  logic mem_we;
  logic [7:0] mem_val;
  logic rise;
  logic cs_fall;
  logic cs_rise;
  logic [5:0] aw;
  logic [5:0] dw;
  logic [5:0] nbits;
  logic [1:0] opf;
  logic [1:0] lead_s;
  logic [1:0] lead_l;
  logic is_short;
  logic is_long;
  logic [FRAME_W-1:0] amask;
  logic [ADDR_W-1:0] a_s;
  logic [ADDR_W-1:0] a_l;
  logic go;
  logic go_all;
  logic go_prog;
  logic [ADDR_W-1:0] go_addr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    mem_we = 1'b0;
    mem_val = ERASED_BYTE;
    go = 1'b0;
    go_all = 1'b0;
    go_prog = 1'b0;
    go_addr = '0;
    // first stage of each synchroniser feeds only the second
    n.cs_m = link.cs;
    n.cs_s = r.cs_m;
    n.cs_p = r.cs_s;
    n.sck_m = link.sclk;
    n.sck_s = r.sck_m;
    n.sck_p = r.sck_s;
    n.sdi_m = link.sdi;
    n.sdi_s = r.sdi_m;
    rise = r.sck_s & ~r.sck_p;
    cs_fall = r.cs_p & ~r.cs_s;
    cs_rise = ~r.cs_p & r.cs_s;
    aw = word_width_select ? 6'(ADDR_W - 1) : 6'(ADDR_W);
    dw = word_width_select ? 6'(WORD_DATA_W) : 6'(BYTE_DATA_W);
    nbits = r.cnt - 6'h01;
    is_short = nbits == 6'(OPCODE_W) + aw;
    is_long = nbits == 6'(OPCODE_W) + aw + dw;
    amask = (FRAME_W'(1) << aw) - FRAME_W'(1);
    opf = 2'(r.sr >> (nbits - 6'h02));
    lead_s = 2'(r.sr >> (aw - 6'h02));
    lead_l = 2'(r.sr >> (dw + aw - 6'h02));
    a_s = ADDR_W'(r.sr & amask);
    a_l = ADDR_W'((r.sr >> dw) & amask);

    case (r.st)
      DEV_IDLE: begin
        if (r.in_frame && rise && r.cnt != 6'h3F) begin
          n.cnt = r.cnt + 6'h01;
          n.sr = {r.sr[FRAME_W-2:0], r.sdi_s};
        end else if (!r.in_frame && r.cs_s && rise && r.sdi_s == START_BIT) begin
          n.in_frame = 1'b1;
          n.cnt = 6'h01;
          n.sr = '0;
          n.stat_en = 1'b0;
        end
        if (cs_fall && r.in_frame) begin
          n.in_frame = 1'b0;
          // a count off by any pulse, early or late select, matches no case
          if (r.cnt >= 6'h03) begin
            case (opf)
              OP_WRITE: begin
                if (is_long) begin
                  go = 1'b1;
                  go_prog = 1'b1;
                  go_addr = a_l;
                end
              end
              OP_ERASE: begin
                if (is_short) begin
                  go = 1'b1;
                  go_addr = a_s;
                end
              end
              OP_EXT: begin
                if (is_short && lead_s == EXT_ERASE_ALL) begin
                  go = 1'b1;
                  go_all = 1'b1;
                end else if (is_short && lead_s == EXT_UNLOCK) begin
                  n.locked = 1'b0;
                end else if (is_short && lead_s == EXT_LOCK) begin
                  n.locked = 1'b1;
                end else if (is_long && lead_l == EXT_FILL) begin
                  go = 1'b1;
                  go_all = 1'b1;
                  go_prog = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
          if (go && !r.locked) begin
            n.st = DEV_TIMED;
            n.timer = TW'(PROG_CYCLES - 1);
            n.prog = go_prog;
            n.pass = 1'b0;
            n.data = 16'(r.sr);
            if (go_all) begin
              n.lo = '0;
              n.hi = '1;
            end else if (word_width_select) begin
              n.lo = {go_addr[ADDR_W-2:0], 1'b0};
              n.hi = {go_addr[ADDR_W-2:0], 1'b1};
            end else begin
              n.lo = go_addr;
              n.hi = go_addr;
            end
          end
        end
      end
      DEV_TIMED: begin
        // counts on clk only; serial input is not looked at here
        n.in_frame = 1'b0;
        if (r.timer == '0) begin
          n.st = DEV_APPLY;
          n.idx = r.lo;
        end else begin
          n.timer = r.timer - TW'(1);
        end
      end
      DEV_APPLY: begin
        // erase pass first, then program pass for write and fill only; one byte per clock
        mem_we = 1'b1;
        if (!r.pass) begin
          mem_val = ERASED_BYTE;
        end else if (word_width_select && r.idx[0]) begin
          mem_val = r.data[15:8];
        end else begin
          mem_val = r.data[7:0];
        end
        if (r.idx != r.hi) begin
          n.idx = r.idx + ADDR_W'(1);
        end else if (!r.pass && r.prog) begin
          n.pass = 1'b1;
          n.idx = r.lo;
        end else begin
          n.st = DEV_IDLE;
        end
      end
      default: begin
        n.st = DEV_IDLE;
      end
    endcase

    if (cs_fall) begin
      n.stat_en = 1'b0;
    end
    if (cs_rise) begin
      n.stat_en = 1'b1;
    end
    n.sdo_out = n.st == DEV_IDLE;
    n.sdo_oe_n = ~(r.cs_s & n.stat_en);
    n.busy = n.st != DEV_IDLE;
    n.peek = mem[peek_addr];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= DEV_IDLE;
      r.locked <= 1'b1;
      r.sdo_out <= 1'b1;
      r.sdo_oe_n <= 1'b1;
      r.peek <= ERASED_BYTE;
    end else begin
      r <= n;
    end
  end

  // delivery state restored by reset; costs a wide reset fan-out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (mem_we) begin
      mem[r.idx] <= mem_val;
    end
  end

  assign link.sdo_out = r.sdo_out;
  assign link.sdo_oe_n = r.sdo_oe_n;
  assign peek_data = r.peek;
  assign busy = r.busy;

endmodule

// ### rtl/seepc_host.sv
/*
  bus master end: builds one instruction frame, shifts it out on a divided
  serial clock, drops select, then raises select and polls for ready.
  assumes one command at a time from the user side, same clk as the device.
*/
`timescale 1ns/1ps
module seepc_host
  import seepc_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int SCLK_HALF = SCLK_HALF_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  seepc_link_if.host link,
  input wire logic word_width_select,
  input wire logic cmd_valid,
  input wire seepc_cmd_type cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_extra_clock,
  output logic cmd_ready,
  output logic cmd_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seepc_hst_st_type st;
    logic [7:0] div;
    logic [5:0] bits;
    logic [FRAME_W-1:0] frame;
    logic cs;
    logic sclk;
    logic sdi;
    logic sdo_m;
    logic sdo_s;
    logic ready;
    logic done;
  } seepc_hst_reg_type;

  seepc_hst_reg_type r;
  seepc_hst_reg_type n;

  logic [5:0] aw;
  logic [5:0] dw;
  logic [5:0] len;
  logic [1:0] op;
  logic [1:0] lead;
  logic ext;
  logic has_data;
  logic [FRAME_W-1:0] v;

  always_comb begin
    n = r;
    n.sdo_m = link.sdo_line;
    n.sdo_s = r.sdo_m;
    n.done = 1'b0;
    aw = word_width_select ? 6'(ADDR_W - 1) : 6'(ADDR_W);
    dw = word_width_select ? 6'(WORD_DATA_W) : 6'(BYTE_DATA_W);
    op = OP_EXT;
    lead = EXT_LOCK;
    ext = 1'b1;
    has_data = 1'b0;
    case (cmd_kind)
      CMD_WRITE: begin
        op = OP_WRITE;
        ext = 1'b0;
        has_data = 1'b1;
      end
      CMD_ERASE: begin
        op = OP_ERASE;
        ext = 1'b0;
      end
      CMD_ERASE_ALL: lead = EXT_ERASE_ALL;
      CMD_FILL: begin
        lead = EXT_FILL;
        has_data = 1'b1;
      end
      CMD_UNLOCK: lead = EXT_UNLOCK;
      default: lead = EXT_LOCK;
    endcase
    // start, opcode, address (extension code in its top two bits, rest zero, for the extended group), optional data
    v = FRAME_W'({START_BIT, op}) << aw;
    if (ext) begin
      v = v | (FRAME_W'(lead) << (aw - 6'h02));
    end else begin
      v = v | (FRAME_W'(cmd_addr) & ((FRAME_W'(1) << aw) - FRAME_W'(1)));
    end
    len = 6'h01 + 6'(OPCODE_W) + aw;
    if (has_data) begin
      v = (v << dw) | (FRAME_W'(cmd_data) & ((FRAME_W'(1) << dw) - FRAME_W'(1)));
      len = len + dw;
    end
    // extra pulse deliberately breaks the count to exercise the abort path
    if (cmd_extra_clock) begin
      v = v << 1;
      len = len + 6'h01;
    end

    case (r.st)
      HST_IDLE: begin
        n.ready = 1'b1;
        if (cmd_valid && r.ready) begin
          n.ready = 1'b0;
          n.st = HST_SHIFT;
          n.frame = v << (6'(FRAME_W) - len);
          n.bits = len;
          n.cs = 1'b1;
          n.sclk = 1'b0;
          n.div = 8'(SCLK_HALF - 1);
        end
      end
      HST_SHIFT: begin
        n.sdi = r.frame[FRAME_W-1];
        if (r.div != 8'h00) begin
          n.div = r.div - 8'h01;
        end else begin
          n.div = 8'(SCLK_HALF - 1);
          if (!r.sclk) begin
            n.sclk = 1'b1;
          end else begin
            n.sclk = 1'b0;
            n.frame = {r.frame[FRAME_W-2:0], 1'b0};
            n.bits = r.bits - 6'h01;
            if (r.bits == 6'h01) begin
              n.cs = 1'b0;
              n.st = HST_GAP;
              n.div = 8'(SLSH_CYCLES);
            end
          end
        end
      end
      HST_GAP: begin
        // data input held low so no start bit is seen while polling
        n.sdi = 1'b0;
        if (r.div != 8'h00) begin
          n.div = r.div - 8'h01;
        end else begin
          n.cs = 1'b1;
          n.st = HST_POLL;
          n.div = 8'(POLL_SETTLE_CYCLES);
        end
      end
      HST_POLL: begin
        if (r.div != 8'h00) begin
          n.div = r.div - 8'h01;
        end else if (r.sdo_s) begin
          n.cs = 1'b0;
          n.done = 1'b1;
          n.st = HST_IDLE;
        end
      end
      default: begin
        n.st = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= HST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign link.cs = r.cs;
  assign link.sclk = r.sclk;
  assign link.sdi = r.sdi;
  assign cmd_ready = r.ready;
  assign cmd_done = r.done;

endmodule

// ### tb/seepc_props.sv
/*
  checker for the serial link between host and device ends: select,
  serial clock and data, the device's status output and its busy flag.
  assumes it is instantiated beside the link interface in the testbench.
*/
`timescale 1ns/1ps
module seepc_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic sdo_line,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // status output
  // ----------------------------------------------------------------
  busy_status_low_a: assert property (
    busy && $past(busy) && !sdo_oe_n |-> !sdo_out)
    else $error("status not low while busy");
  ready_status_high_a: assert property (
    !sdo_oe_n && !busy && !$past(busy) && !$past(busy, 2) |-> sdo_out)
    else $error("status not high while idle");
  release_on_low_a: assert property (!cs [*5] |-> sdo_oe_n)
    else $error("status driven with select low");

  // ----------------------------------------------------------------
  // self-timed cycle
  // ----------------------------------------------------------------
  // busy may only start a few cycles after select has fallen
  busy_start_fall_a: assert property ($rose(busy) |-> !cs && $past(cs, 6))
    else $error("busy started without select fall");
  busy_holds_a: assert property ($rose(busy) |-> busy [*8])
    else $error("busy ended too early");
  busy_bounded_a: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("busy never ended");

  // ----------------------------------------------------------------
  // host framing
  // ----------------------------------------------------------------
  cs_fall_clock_a: assert property ($fell(cs) |-> !sclk)
    else $error("select fell with serial clock high");
  sdi_stable_rise_a: assert property ($rose(sclk) |-> $stable(sdi) && cs)
    else $error("data moved at serial clock rise");

  busy_seen_c: cover property ($rose(busy));
  busy_polled_c: cover property (busy && cs && !sdo_line);
  ready_polled_c: cover property (!busy && cs && !sdo_oe_n && sdo_line);
endmodule

// ### tb/seepc_tb.sv
/*
  self-checking bench: host and device ends joined by the link interface;
  commands go in on the host's user side, results are read back through
  the device's peek port. assumes small counts so the run stays short.
*/
`timescale 1ns/1ps
module seepc_tb;
  import seepc_pkg::*;
  localparam int AW = 5;
  localparam int NB = 1 << AW;
  logic clk, sys_rst, wws, cmd_valid, cmd_extra_clock, cmd_ready, cmd_done, busy;
  logic busy_seen;
  seepc_cmd_type cmd_kind;
  logic [AW-1:0] cmd_addr, peek_addr;
  logic [15:0] cmd_data;
  logic [7:0] peek_data;
  int n_errors, check_count, cycles;

  seepc_link_if link ();
  seepc_device #(.ADDR_W(AW), .PROG_CYCLES(8)) seepc_device_inst (
    .clk(clk), .sys_rst(sys_rst), .link(link), .word_width_select(wws),
    .peek_addr(peek_addr), .peek_data(peek_data), .busy(busy));
  seepc_host #(.ADDR_W(AW), .SCLK_HALF(3)) seepc_host_inst (
    .clk(clk), .sys_rst(sys_rst), .link(link), .word_width_select(wws),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_extra_clock(cmd_extra_clock), .cmd_ready(cmd_ready), .cmd_done(cmd_done));
  seepc_props seepc_props_inst (
    .clk(clk), .sys_rst(sys_rst), .cs(link.cs), .sclk(link.sclk), .sdi(link.sdi),
    .sdo_out(link.sdo_out), .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line),
    .busy(busy));

  // ----------------------------------------------------------------
  // clock, timeout, status monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (busy === 1'b1 && link.cs === 1'b1 && link.sdo_line === 1'b0) begin
      busy_seen = 1'b1;
    end
    if (cycles == 40000) begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one command through the host; a missing completion counts as a mismatch
  task automatic send(input seepc_cmd_type kind, input logic [AW-1:0] addr,
                      input logic [15:0] data, input logic extra);
    int n;
    n = 0;
    @(posedge clk);
    #2;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_kind = kind;
    cmd_addr = addr;
    cmd_data = data;
    cmd_extra_clock = extra;
    @(posedge clk);
    #2 cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_val("command done", 8'h01, {7'h00, cmd_done});
  endtask

  task automatic check_mem(input logic [AW-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    #2 peek_addr = a;
    @(posedge clk);
    @(posedge clk);
    #1 check_val("array byte", exp, peek_data);
  endtask

  task automatic check_all(input logic [7:0] even, input logic [7:0] odd);
    for (int i = 0; i < NB; i++) begin
      check_mem(i[AW-1:0], i[0] ? odd : even);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    wws = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_WRITE;
    cmd_addr = '0;
    cmd_data = 16'h0000;
    cmd_extra_clock = 1'b0;
    peek_addr = '0;
    busy_seen = 1'b0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    check_all(8'hFF, 8'hFF);
    // locked from power-up: a write must leave the byte alone
    send(CMD_WRITE, 5'h03, 16'h00A5, 1'b0);
    check_mem(5'h03, 8'hFF);
    send(CMD_UNLOCK, 5'h00, 16'h0000, 1'b0);
    send(CMD_WRITE, 5'h03, 16'h005A, 1'b0);
    check_mem(5'h03, 8'h5A);
    // complementary pattern over the old one must replace every bit of it
    send(CMD_WRITE, 5'h03, 16'h00A5, 1'b0);
    check_mem(5'h03, 8'hA5);
    send(CMD_WRITE, 5'h03, 16'h0000, 1'b1);
    check_mem(5'h03, 8'hA5);
    send(CMD_ERASE, 5'h03, 16'h0000, 1'b1);
    check_mem(5'h03, 8'hA5);
    send(CMD_ERASE, 5'h03, 16'h0000, 1'b0);
    check_mem(5'h03, 8'hFF);
    send(CMD_FILL, 5'h15, 16'h003C, 1'b0);
    check_all(8'h3C, 8'h3C);
    send(CMD_ERASE_ALL, 5'h00, 16'h0000, 1'b1);
    check_mem(5'h00, 8'h3C);
    send(CMD_ERASE_ALL, 5'h00, 16'h0000, 1'b0);
    check_all(8'hFF, 8'hFF);
    // word organisation: word address 2 covers bytes 4 and 5
    @(posedge clk);
    #2 wws = 1'b1;
    send(CMD_WRITE, 5'h02, 16'h1234, 1'b0);
    check_mem(5'h04, 8'h34);
    check_mem(5'h05, 8'h12);
    send(CMD_WRITE, 5'h02, 16'h5678, 1'b1);
    check_mem(5'h05, 8'h12);
    send(CMD_FILL, 5'h00, 16'hBEEF, 1'b0);
    check_all(8'hEF, 8'hBE);
    send(CMD_ERASE, 5'h02, 16'h0000, 1'b0);
    check_mem(5'h04, 8'hFF);
    check_mem(5'h05, 8'hFF);
    send(CMD_LOCK, 5'h00, 16'h0000, 1'b0);
    send(CMD_WRITE, 5'h00, 16'h0000, 1'b0);
    check_mem(5'h00, 8'hEF);
    check_val("busy status seen", 8'h01, {7'h00, busy_seen});
    stop_test();
  end
endmodule
